// ===== rtl/spllc_pkg.sv
package spllc_pkg;
    // Register offsets on the serial control port.
    localparam logic [14:0] ADDR_NOISE = 15'h002b;
    localparam logic [14:0] ADDR_FBDIV_A = 15'h003d;
    localparam logic [14:0] ADDR_FBDIV_B = 15'h003e;
    localparam logic [14:0] ADDR_HOLD = 15'h005c;
    localparam logic [14:0] ADDR_CAL_CTRL = 15'h005d;
    localparam logic [14:0] ADDR_CAL_STAT = 15'h005e;
    localparam logic [14:0] ADDR_CLKOUT = 15'h0060;
    localparam logic [14:0] ADDR_TRIG = 15'h0061;
    localparam logic [14:0] ADDR_LINK_STAT = 15'h0208;

    // Field positions.
    localparam int HOLD_BIT = 0;
    localparam int CAL_EN_BIT = 0;
    localparam int CAL_DONE_BIT = 0;
    localparam int LOCK_BIT = 0;
    localparam int REFO_EN_BIT = 0;
    localparam int OVRD_BIT = 1;
    localparam int AUXC_LSB = 2;
    localparam int AUXD_LSB = 4;
    localparam int OVERRANGE_ENABLE_BIT = 6;
    localparam int TRIG_EN_BIT = 0;
    localparam int TRIG_SEL_LSB = 1;
    localparam int RXDIV_LSB = 3;
    localparam int PRESCALE_LSB = 4;

    // Values after reset.
    localparam logic [7:0] RST_HOLD = 8'h01;
    localparam logic [7:0] RST_CLKOUT = 8'h01;
    localparam logic [7:0] RST_TRIG = 8'h00;
    localparam logic [7:0] RST_ZERO = 8'h00;

    // Trigger source code that repeats the timestamp input.
    localparam logic [1:0] TRIG_SEL_STAMP = 2'h3;

    // Serial frame: read flag, 15 address bits, 8 data bits.
    localparam int FRAME_BITS = 24;
    localparam int ADDR_BITS_END = 16;

    // Calibration and lock settle times.
    localparam int CLK_PERIOD_NS = 10;
    localparam int CAL_TIME_NS = 2000;
    localparam int LOCK_TIME_NS = 1000;
    localparam int CAL_CYCLES =
        (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOCK_CYCLES =
        (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_HOLD = 2'b00,
        ST_CAL = 2'b01,
        ST_LOCKING = 2'b11,
        ST_LOCKED = 2'b10
    } spllc_state_t;
endpackage

// ===== rtl/spllc_top.sv
// Function
// - Prescale and oscillator divider in one register, feedback next.
// - Releasing hold-reset with calibration on runs calibration, then PLL.
// - Calibration-done and lock flags read 1 when finished and locked.
// - Reference output forwards the selected reference input undivided.
// - Reference output on when PLL enabled, off when enable is 0.
// - Reference output toggles only with PLL pin high, powerdown low.
// - Trigger output off until enabled; source timestamp or serializer.
// - Serializer source gives serializer clock divided by the divider.
// - Auxiliary outputs follow configuration pins; powerdown disables them.
// - Pins select C enable and divider, D enable only; override wins.
// - Divided reference takes precedence over the over-range function.
// - Clock on output D only when output C select is above 0.
// - Output C codes: over-range or off, ref, ref/2, ref/4.
// - Output D: pins give off/over-range or ref; codes as C.
// - PLL reference is single-ended input when select pin high.
// - Timestamp repeats on trigger output when enabled with select 3.
module spllc_top #(
    parameter bit IS_QUAD = 1'b1
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic sys_rst,
    // Serial control port.
    input wire logic spi_csn,
    input wire logic spi_sclk,
    input wire logic spi_sdi,
    output logic spi_sdo,
    // Reference inputs and configuration pins.
    input wire logic ref_diff_in,
    input wire logic single_ended_ref_in,
    input wire logic ref_single_ended_sel,
    input wire logic pll_enable_pin,
    input wire logic powerdown_pin,
    input wire logic [1:0] clock_config_pins,
    // Serializer clock, timestamp and over-range indicators.
    input wire logic serdes_clk_in,
    input wire logic timestamp_in,
    input wire logic overrange_c_in,
    input wire logic overrange_d_in,
    // Clock outputs.
    output logic ref_clock_out,
    output logic trigger_clock_out,
    output logic aux_out_c,
    output logic aux_out_d,
    // Sampling PLL controls to the analog core.
    output logic pll_released,
    output logic osc_cal_active,
    output logic [3:0] pll_prescale,
    output logic [3:0] pll_osc_div,
    output logic [7:0] pll_fb_div,
    output logic [7:0] noise_ctrl
);
    localparam int A_CAL = spllc_pkg::CAL_CYCLES;

    // Every pin except the over-range inputs passes two flip-flops; the third stage feeds edge finders.
    logic [11:0] sync1_ff, sync2_ff, sync3_ff;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            sync3_ff <= '0;
        end else begin
            sync1_ff <= {spi_csn, spi_sclk, spi_sdi, ref_diff_in,
                single_ended_ref_in, ref_single_ended_sel, pll_enable_pin,
                powerdown_pin, clock_config_pins, serdes_clk_in,
                timestamp_in};
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    logic csn_s, sclk_s, sdi_s, diff_s, se_s, sel_s, pllen_s, pd_s, ser_s;
    logic ts_s, sclk_rise, sclk_fall, ser_edge;
    logic [1:0] cfg_s;
    assign {csn_s, sclk_s, sdi_s, diff_s, se_s, sel_s, pllen_s, pd_s,
        cfg_s, ser_s, ts_s} = sync2_ff;
    assign sclk_rise = sclk_s && !sync3_ff[10];
    assign sclk_fall = !sclk_s && sync3_ff[10];
    assign ser_edge = ser_s != sync3_ff[1];

    // Register file and serial shifter.
    logic [7:0] noise_ff, fba_ff, fbb_ff, hold_ff, calc_ff, clko_ff, trig_ff;
    logic [7:0] nxt_noise, nxt_fba, nxt_fbb, nxt_hold, nxt_calc;
    logic [7:0] nxt_clko, nxt_trig, out_ff, nxt_out;
    logic [23:0] shift_ff, nxt_shift, frame;
    logic [4:0] cnt_ff, nxt_cnt;
    logic sdo_ff, nxt_sdo, done_ff, lock_ff;

    function automatic logic [7:0] reg_read(input logic [14:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == spllc_pkg::ADDR_NOISE) begin
            v = noise_ff;
        end else if (a == spllc_pkg::ADDR_FBDIV_A) begin
            v = fba_ff;
        end else if (a == spllc_pkg::ADDR_FBDIV_B) begin
            v = fbb_ff;
        end else if (a == spllc_pkg::ADDR_HOLD) begin
            v = hold_ff;
        end else if (a == spllc_pkg::ADDR_CAL_CTRL) begin
            v = calc_ff;
        end else if (a == spllc_pkg::ADDR_CAL_STAT) begin
            v[spllc_pkg::CAL_DONE_BIT] = done_ff;
        end else if (a == spllc_pkg::ADDR_CLKOUT) begin
            v = clko_ff;
        end else if (a == spllc_pkg::ADDR_TRIG) begin
            v = trig_ff;
        end else if (a == spllc_pkg::ADDR_LINK_STAT) begin
            v[spllc_pkg::LOCK_BIT] = lock_ff;
        end
        return v;
    endfunction

    // Bits shift in on serial clock rises, out on falls; unmapped reads 0.
    always_comb begin
        frame = {shift_ff[22:0], sdi_s};
        nxt_shift = shift_ff;
        nxt_cnt = cnt_ff;
        nxt_out = out_ff;
        nxt_sdo = sdo_ff;
        nxt_noise = noise_ff;
        nxt_fba = fba_ff;
        nxt_fbb = fbb_ff;
        nxt_hold = hold_ff;
        nxt_calc = calc_ff;
        nxt_clko = clko_ff;
        nxt_trig = trig_ff;
        if (csn_s) begin
            nxt_cnt = 5'h00;
            nxt_sdo = 1'b0;
        end else if (sclk_rise) begin
            nxt_shift = frame;
            nxt_cnt = cnt_ff + 5'h01;
            if (cnt_ff == 5'(spllc_pkg::ADDR_BITS_END - 1) && frame[15]) begin
                nxt_out = reg_read(frame[14:0]);
            end
            if (cnt_ff == 5'(spllc_pkg::FRAME_BITS - 1) && !frame[23]) begin
                if (frame[22:8] == spllc_pkg::ADDR_FBDIV_A) begin
                    nxt_fba = frame[7:0];
                end else if (frame[22:8] == spllc_pkg::ADDR_FBDIV_B) begin
                    nxt_fbb = frame[7:0];
                end else if (frame[22:8] == spllc_pkg::ADDR_NOISE) begin
                    nxt_noise = frame[7:0];
                end else if (frame[22:8] == spllc_pkg::ADDR_HOLD) begin
                    nxt_hold = frame[7:0];
                end else if (frame[22:8] == spllc_pkg::ADDR_CAL_CTRL) begin
                    nxt_calc = frame[7:0];
                end else if (frame[22:8] == spllc_pkg::ADDR_CLKOUT) begin
                    nxt_clko = frame[7:0];
                end else if (frame[22:8] == spllc_pkg::ADDR_TRIG) begin
                    nxt_trig = frame[7:0];
                end
            end
        end else if (sclk_fall && cnt_ff >= 5'(spllc_pkg::ADDR_BITS_END)) begin
            nxt_sdo = out_ff[7];
            nxt_out = {out_ff[6:0], 1'b0};
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            shift_ff <= '0;
            cnt_ff <= 5'h00;
            out_ff <= spllc_pkg::RST_ZERO;
            sdo_ff <= 1'b0;
            noise_ff <= spllc_pkg::RST_ZERO;
            fba_ff <= spllc_pkg::RST_ZERO;
            fbb_ff <= spllc_pkg::RST_ZERO;
            hold_ff <= spllc_pkg::RST_HOLD;
            calc_ff <= spllc_pkg::RST_ZERO;
            clko_ff <= spllc_pkg::RST_CLKOUT;
            trig_ff <= spllc_pkg::RST_TRIG;
        end else begin
            shift_ff <= nxt_shift;
            cnt_ff <= nxt_cnt;
            out_ff <= nxt_out;
            sdo_ff <= nxt_sdo;
            noise_ff <= nxt_noise;
            fba_ff <= nxt_fba;
            fbb_ff <= nxt_fbb;
            hold_ff <= nxt_hold;
            calc_ff <= nxt_calc;
            clko_ff <= nxt_clko;
            trig_ff <= nxt_trig;
        end
    end

    logic hold, cal_en, refo_en, ovrd, overrange_enable, trig_en;
    logic [1:0] auxc_sel, auxd_sel, trig_sel;
    logic [3:0] rx_div;
    assign hold = hold_ff[spllc_pkg::HOLD_BIT];
    assign cal_en = calc_ff[spllc_pkg::CAL_EN_BIT];
    assign refo_en = clko_ff[spllc_pkg::REFO_EN_BIT];
    assign ovrd = clko_ff[spllc_pkg::OVRD_BIT];
    assign overrange_enable = clko_ff[spllc_pkg::OVERRANGE_ENABLE_BIT];
    assign auxc_sel = clko_ff[spllc_pkg::AUXC_LSB +: 2];
    assign auxd_sel = clko_ff[spllc_pkg::AUXD_LSB +: 2];
    assign trig_en = trig_ff[spllc_pkg::TRIG_EN_BIT];
    assign trig_sel = trig_ff[spllc_pkg::TRIG_SEL_LSB +: 2];
    assign rx_div = trig_ff[spllc_pkg::RXDIV_LSB +: 4];

    // Calibration and lock sequence; any hold drops the PLL at once.
    spllc_pkg::spllc_state_t st_ff, nxt_st;
    logic [7:0] tmr_ff, nxt_tmr;
    logic nxt_done, nxt_lock, nxt_rel, nxt_cala, rel_ff, cala_ff;
    always_comb begin
        nxt_st = st_ff;
        nxt_tmr = tmr_ff;
        nxt_done = done_ff;
        nxt_lock = lock_ff;
        case (st_ff)
            spllc_pkg::ST_HOLD: begin
                if (cal_en) begin
                    nxt_st = spllc_pkg::ST_CAL;
                    nxt_tmr = 8'(spllc_pkg::CAL_CYCLES - 1);
                end else begin
                    nxt_st = spllc_pkg::ST_LOCKING;
                    nxt_tmr = 8'(spllc_pkg::LOCK_CYCLES - 1);
                end
            end
            spllc_pkg::ST_CAL: begin
                if (tmr_ff == 8'h00) begin
                    nxt_done = 1'b1;
                    nxt_st = spllc_pkg::ST_LOCKING;
                    nxt_tmr = 8'(spllc_pkg::LOCK_CYCLES - 1);
                end else begin
                    nxt_tmr = tmr_ff - 8'h01;
                end
            end
            spllc_pkg::ST_LOCKING: begin
                if (tmr_ff == 8'h00) begin
                    nxt_lock = 1'b1;
                    nxt_st = spllc_pkg::ST_LOCKED;
                end else begin
                    nxt_tmr = tmr_ff - 8'h01;
                end
            end
            default: begin
                nxt_st = spllc_pkg::ST_LOCKED;
            end
        endcase
        if (hold || !pllen_s || pd_s) begin
            nxt_st = spllc_pkg::ST_HOLD;
            nxt_done = 1'b0;
            nxt_lock = 1'b0;
        end
        // Status outputs are decoded ahead so that they leave from flops.
        nxt_rel = nxt_st != spllc_pkg::ST_HOLD;
        nxt_cala = nxt_st == spllc_pkg::ST_CAL;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff <= spllc_pkg::ST_HOLD;
            tmr_ff <= 8'h00;
            done_ff <= 1'b0;
            lock_ff <= 1'b0;
            rel_ff <= 1'b0;
            cala_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            tmr_ff <= nxt_tmr;
            done_ff <= nxt_done;
            lock_ff <= nxt_lock;
            rel_ff <= nxt_rel;
            cala_ff <= nxt_cala;
        end
    end

    // Over-range is the fallback of code 0 only, so a clock always wins.
    function automatic logic aux_pick(input logic [1:0] code,
        input logic orng, input logic refc, input logic [1:0] div);
        logic v;
        v = 1'b0;
        case (code)
            2'h0: v = IS_QUAD && overrange_enable && orng;
            2'h1: v = refc;
            2'h2: v = div[0];
            default: v = div[1];
        endcase
        return v;
    endfunction

    // Clock outputs; edges of the slow pins are seen three cycles late.
    logic refc, ref_d_ff, tog_ff, nxt_tog;
    logic refo_ff, trigo_ff, auxc_ff, auxd_ff;
    logic nxt_refo, nxt_trigo, nxt_auxc, nxt_auxd;
    logic [1:0] div_ff, nxt_div, c_code, d_code;
    logic [3:0] scnt_ff, nxt_scnt;
    always_comb begin
        refc = sel_s ? se_s : diff_s;
        nxt_div = (refc && !ref_d_ff) ? div_ff + 2'h1 : div_ff;
        nxt_refo = pllen_s && !pd_s && refo_en && refc;
        nxt_scnt = scnt_ff;
        nxt_tog = tog_ff;
        if (ser_edge) begin
            if (scnt_ff + 4'h1 >= rx_div) begin
                nxt_scnt = 4'h0;
                nxt_tog = !tog_ff;
            end else begin
                nxt_scnt = scnt_ff + 4'h1;
            end
        end
        if (!trig_en || pd_s) begin
            nxt_trigo = 1'b0;
        end else if (trig_sel == spllc_pkg::TRIG_SEL_STAMP) begin
            nxt_trigo = ts_s;
        end else begin
            nxt_trigo = tog_ff;
        end
        c_code = ovrd ? auxc_sel : cfg_s;
        d_code = ovrd ? auxd_sel : {1'b0, cfg_s != 2'h0};
        if (c_code == 2'h0) begin
            d_code = 2'h0;
        end
        nxt_auxc = !pd_s && aux_pick(c_code, overrange_c_in, refc, div_ff);
        nxt_auxd = !pd_s && aux_pick(d_code, overrange_d_in, refc, div_ff);
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ref_d_ff <= 1'b0;
            div_ff <= 2'h0;
            scnt_ff <= 4'h0;
            tog_ff <= 1'b0;
            refo_ff <= 1'b0;
            trigo_ff <= 1'b0;
            auxc_ff <= 1'b0;
            auxd_ff <= 1'b0;
        end else begin
            ref_d_ff <= refc;
            div_ff <= nxt_div;
            scnt_ff <= nxt_scnt;
            tog_ff <= nxt_tog;
            refo_ff <= nxt_refo;
            trigo_ff <= nxt_trigo;
            auxc_ff <= nxt_auxc;
            auxd_ff <= nxt_auxd;
        end
    end

    assign spi_sdo = sdo_ff;
    assign ref_clock_out = refo_ff;
    assign trigger_clock_out = trigo_ff;
    assign aux_out_c = auxc_ff;
    assign aux_out_d = auxd_ff;
    assign pll_released = rel_ff;
    assign osc_cal_active = cala_ff;
    assign pll_prescale = fba_ff[spllc_pkg::PRESCALE_LSB +: 4];
    assign pll_osc_div = fba_ff[3:0];
    assign pll_fb_div = fbb_ff;
    assign noise_ctrl = noise_ff;

    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_release;
        st_ff == spllc_pkg::ST_HOLD && !hold && pllen_s && !pd_s && cal_en;
    endsequence
    sequence s_cal_entry;
        st_ff == spllc_pkg::ST_HOLD ##1 st_ff == spllc_pkg::ST_CAL;
    endsequence

    a_hold_flags_low: assert property (hold |=> !done_ff && !lock_ff)
        else $error("flags set during hold");
    a_release_cal: assert property (s_release |=> osc_cal_active)
        else $error("calibration did not start");
    a_cal_length: assert property (s_cal_entry |-> ##A_CAL
        (done_ff || st_ff == spllc_pkg::ST_HOLD))
        else $error("calibration length wrong");
    a_lock_after_cal: assert property ($rose(lock_ff) && cal_en |-> done_ff)
        else $error("lock before calibration done");
    a_ref_gate: assert property (!pllen_s || pd_s |=> !ref_clock_out)
        else $error("reference output ran while gated");
    a_ref_follow: assert property (pllen_s && !pd_s && refo_en |=>
        ref_clock_out == $past(refc))
        else $error("reference output not following input");
    a_ref_disable: assert property (!refo_en |=> !ref_clock_out)
        else $error("reference output on while disabled");
    a_trig_off: assert property (!trig_en |=> !trigger_clock_out)
        else $error("trigger output on while disabled");
    a_trig_stamp: assert property (trig_en && !pd_s &&
        trig_sel == spllc_pkg::TRIG_SEL_STAMP |=>
        trigger_clock_out == $past(ts_s))
        else $error("timestamp not repeated");
    a_aux_pd: assert property (pd_s |=> !aux_out_c && !aux_out_d)
        else $error("auxiliary output on in powerdown");
    a_aux_c_pins: assert property (!ovrd && !pd_s && cfg_s == 2'h1 |=>
        aux_out_c == $past(refc))
        else $error("output C not undivided reference");
    a_aux_d_gate: assert property (c_code == 2'h0 |=> aux_out_d ==
        $past(!pd_s && IS_QUAD && overrange_enable && overrange_d_in))
        else $error("output D clock without output C");
endmodule

// ===== tb/spllc_fpga_rx.sv
// Receiving logic at the far end: counts rising edges of each clock output.
module spllc_fpga_rx (
    // Clock and measurement control.
    input wire logic core_clk,
    input wire logic clr,
    // Clocks from the converter: ref, trigger, aux C, aux D.
    input wire logic [3:0] clks,
    // Edge counts, one per clock.
    output logic [15:0] cnt [4]
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] prev_ff;

    // Edges are seen on the core clock, so inputs must stay below half its rate.
    always_ff @(posedge core_clk) begin
        prev_ff <= clks;
        for (int i = 0; i < 4; i++) begin
            if (clr) begin
                cnt[i] <= 16'h0000;
            end else if (clks[i] && !prev_ff[i]) begin
                cnt[i] <= cnt[i] + 16'h0001;
            end
        end
    end
endmodule

// ===== tb/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk, sys_rst, spi_csn, spi_sclk, spi_sdi, spi_sdo;
    logic ref_diff_in, single_ended_ref_in, ref_single_ended_sel;
    logic pll_enable_pin, powerdown_pin, serdes_clk_in, timestamp_in;
    logic [1:0] clock_config_pins;
    logic overrange_c_in, overrange_d_in, ref_clock_out, trigger_clock_out;
    logic aux_out_c, aux_out_d, pll_released, osc_cal_active, clr;
    logic [3:0] pll_prescale, pll_osc_div;
    logic [7:0] pll_fb_div, noise_ctrl, rdv;
    logic [15:0] cnt [4];
    int bad_count, checks_done, div_cnt;

    spllc_top spllc_top_inst (.core_clk, .sys_rst, .spi_csn, .spi_sclk,
        .spi_sdi, .spi_sdo, .ref_diff_in, .single_ended_ref_in,
        .ref_single_ended_sel, .pll_enable_pin, .powerdown_pin,
        .clock_config_pins, .serdes_clk_in, .timestamp_in, .overrange_c_in,
        .overrange_d_in, .ref_clock_out, .trigger_clock_out, .aux_out_c,
        .aux_out_d, .pll_released, .osc_cal_active, .pll_prescale,
        .pll_osc_div, .pll_fb_div, .noise_ctrl);

    spllc_fpga_rx spllc_fpga_rx_inst (.core_clk, .clr, .cnt,
        .clks({aux_out_d, aux_out_c, trigger_clock_out, ref_clock_out}));

    // Free-running core clock at 100 MHz.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Slow source clocks: periods of 8, 10, 4 and 14 core cycles.
    // every periodic source is an integer division of core_clk.
    always @(posedge core_clk) begin
        div_cnt <= div_cnt + 1;
        if (div_cnt % 4 == 3) ref_diff_in <= ~ref_diff_in;
        if (div_cnt % 5 == 4) single_ended_ref_in <= ~single_ended_ref_in;
        if (div_cnt % 2 == 1) serdes_clk_in <= ~serdes_clk_in;
        if (div_cnt % 7 == 6) timestamp_in <= ~timestamp_in;
    end

    // Compares one value and logs any difference.
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Edge counts depend on phase, so one edge either way is accepted.
    task automatic near(input logic [15:0] seen, input logic [15:0] exp);
        chk((seen + 16'h1 >= exp && seen <= exp + 16'h1) ? exp : seen, exp);
    endtask

    // One 24-bit serial frame; sclk levels last 7 core cycles for the sync.
    task automatic spi(input logic rd, input logic [14:0] a,
                       input logic [7:0] wd, output logic [7:0] rv);
        logic [23:0] f;
        f = {rd, a, wd};
        rv = 8'h00;
        @(posedge core_clk) spi_csn <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            @(posedge core_clk) spi_sdi <= f[i];
            repeat (6) @(posedge core_clk);
            if (i < 8) rv[i] = spi_sdo;
            spi_sclk <= 1'b1;
            repeat (7) @(posedge core_clk);
            spi_sclk <= 1'b0;
        end
        repeat (6) @(posedge core_clk);
        spi_csn <= 1'b1;
        repeat (5) @(posedge core_clk);
    endtask

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] unused;
        spi(1'b0, a, d, unused);
    endtask

    task automatic rd(input logic [14:0] a, input logic [7:0] e);
        spi(1'b1, a, 8'h00, rdv);
        chk({8'h00, rdv}, {8'h00, e});
    endtask

    // Waits 8 cycles to settle, clears the far-end counters, then lets 400 cycles pass.
    task automatic meas;
        repeat (8) @(posedge core_clk);
        clr <= 1'b1;
        @(posedge core_clk) clr <= 1'b0;
        repeat (400) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    task automatic final_report;
        $display("checks=%0d mismatches=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Cuts a hang short well beyond the expected 18100 cycles or so.
    initial begin
        repeat (80000) @(posedge core_clk);
        bad_count++;
        final_report;
    end

    // Main sequence of tests.
    initial begin
        {sys_rst, spi_csn, pll_enable_pin} = 3'b111;
        {spi_sclk, spi_sdi, ref_diff_in, single_ended_ref_in} = 4'h0;
        {ref_single_ended_sel, powerdown_pin, serdes_clk_in} = 3'b000;
        {timestamp_in, overrange_c_in, overrange_d_in, clr} = 4'h0;
        {clock_config_pins, div_cnt, bad_count, checks_done} = '0;
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge core_clk);
        rd(spllc_pkg::ADDR_HOLD, spllc_pkg::RST_HOLD);
        rd(spllc_pkg::ADDR_CAL_STAT, 8'h00);
        rd(spllc_pkg::ADDR_LINK_STAT, 8'h00);
        rd(spllc_pkg::ADDR_CLKOUT, spllc_pkg::RST_CLKOUT);
        rd(spllc_pkg::ADDR_TRIG, spllc_pkg::RST_TRIG);
        rd(15'h0100, 8'h00);
        meas;
        chk(cnt[1], 16'h0000);
        near(cnt[0], 16'd50);
        chk(cnt[2], 16'h0000);
        chk(cnt[3], 16'h0000);
        $display("test reset done");
        wr(spllc_pkg::ADDR_FBDIV_A, 8'ha5);
        wr(spllc_pkg::ADDR_FBDIV_B, 8'h3c);
        wr(spllc_pkg::ADDR_NOISE, 8'h5a);
        rd(spllc_pkg::ADDR_FBDIV_A, 8'ha5);
        rd(spllc_pkg::ADDR_FBDIV_B, 8'h3c);
        chk({pll_prescale, pll_osc_div, pll_fb_div}, 16'ha53c);
        chk({8'h00, noise_ctrl}, 16'h005a);
        $display("test dividers done");
        wr(spllc_pkg::ADDR_CAL_CTRL, 8'h01);
        wr(spllc_pkg::ADDR_HOLD, 8'h00);
        repeat (3) @(posedge core_clk);
        chk({15'h0, osc_cal_active & pll_released}, 16'h0001);
        repeat (150) @(posedge core_clk);
        chk({15'h0, osc_cal_active}, 16'h0001);
        repeat (100) @(posedge core_clk);
        chk({15'h0, osc_cal_active}, 16'h0000);
        wr(spllc_pkg::ADDR_CAL_STAT, 8'h00);
        rd(spllc_pkg::ADDR_CAL_STAT, 8'h01);
        rd(spllc_pkg::ADDR_LINK_STAT, 8'h01);
        wr(spllc_pkg::ADDR_HOLD, 8'h01);
        rd(spllc_pkg::ADDR_CAL_STAT, 8'h00);
        rd(spllc_pkg::ADDR_LINK_STAT, 8'h00);
        chk({15'h0, pll_released}, 16'h0000);
        $display("test calibration done");
        @(posedge core_clk) ref_single_ended_sel <= 1'b1;
        meas;
        near(cnt[0], 16'd40);
        @(posedge core_clk) ref_single_ended_sel <= 1'b0;
        meas;
        near(cnt[0], 16'd50);
        wr(spllc_pkg::ADDR_CLKOUT, 8'h00);
        meas;
        chk(cnt[0], 16'h0000);
        wr(spllc_pkg::ADDR_CLKOUT, 8'h01);
        @(posedge core_clk) pll_enable_pin <= 1'b0;
        meas;
        chk(cnt[0], 16'h0000);
        @(posedge core_clk) pll_enable_pin <= 1'b1;
        $display("test reference output done");
        // Pin codes 1..3 give ref, ref/2, ref/4 on C and plain ref on D.
        for (int p = 1; p < 4; p++) begin
            @(posedge core_clk) clock_config_pins <= 2'(p);
            meas;
            near(cnt[2], 16'd50 >> (p - 1));
            near(cnt[3], 16'd50);
        end
        @(posedge core_clk) powerdown_pin <= 1'b1;
        meas;
        chk(cnt[0], 16'h0000);
        chk(cnt[2], 16'h0000);
        chk({15'h0, aux_out_c | aux_out_d}, 16'h0000);
        @(posedge core_clk) powerdown_pin <= 1'b0;
        @(posedge core_clk) clock_config_pins <= 2'b00;
        for (int k = 1; k < 4; k++) begin
            wr(spllc_pkg::ADDR_CLKOUT, 8'h03 | 8'(k << 2) | 8'((4 - k) << 4));
            meas;
            near(cnt[2], 16'd50 >> (k - 1));
            near(cnt[3], 16'd50 >> (3 - k));
        end
        wr(spllc_pkg::ADDR_CLKOUT, 8'h13);
        meas;
        chk(cnt[3], 16'h0000);
        @(posedge core_clk) {overrange_c_in, overrange_d_in} <= 2'b11;
        wr(spllc_pkg::ADDR_CLKOUT, 8'h41);
        chk({14'h0, aux_out_c, aux_out_d}, 16'h0003);
        @(posedge core_clk) clock_config_pins <= 2'b01;
        meas;
        near(cnt[2], 16'd50);
        @(posedge core_clk) {overrange_c_in, overrange_d_in} <= 2'b00;
        $display("test auxiliary outputs done");
        wr(spllc_pkg::ADDR_TRIG, 8'h07);
        meas;
        near(cnt[1], 16'd28);
        wr(spllc_pkg::ADDR_TRIG, 8'h21);
        meas;
        near(cnt[1], 16'd25);
        wr(spllc_pkg::ADDR_TRIG, 8'h11);
        meas;
        near(cnt[1], 16'd50);
        wr(spllc_pkg::ADDR_TRIG, 8'h20);
        meas;
        chk(cnt[1], 16'h0000);
        $display("test trigger output done");
        final_report;
    end
endmodule
